// >>> verilog/acq_irq_and_line_counter_ctrl.sv
/*
  Acquisition control bank: freeze source, DMA test bit, six interrupt flags
  with masks, five of them with host write select, and line position counter control.
  Assumes a one-cycle register port master and camera inputs on mclk.
*/
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "acq_ctrl_regs.svh"
module acq_irq_and_line_counter_ctrl #(
    parameter int CNT_W = 14
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [31:0]       rd_data_ff,
    input  wire logic              trigger_in,
    input  wire logic              encoder_in,
    input  wire logic              frame_enable_in,
    input  wire logic              line_enable_in,
    input  wire logic              line_advance,
    input  wire logic              haw_end,
    input  wire logic              horiz_table_reset_column,
    input  wire logic              horiz_table_load_enable,
    input  wire logic              vert_table_irq_column,
    input  wire logic              fifo_overflow,
    input  wire logic              hw_exception,
    input  wire logic              sync_lost,
    input  wire logic              descriptor_irq_req,
    input  wire logic              uart_irq_set,
    input  wire logic              uart_host_write,
    input  wire logic              software_reset_strobe,
    input  wire logic              abort_cmd,
    input  wire logic              host_freeze_cmd,
    input  wire logic              acq_counter_done,
    output logic                   freeze_request_ff,
    output logic                   dma_unthrottled_test_ff,
    output logic                   irq_request_ff,
    output logic                   frame_counter_clear_ff,
    output logic                   memory_pointer_clear_ff,
    output logic [CNT_W-1:0]       line_position_counter
);
    // Flag order, also the mask bit order: table, overflow, fault,
    // trigger, serial, descriptor.
    localparam int F_TAB = 0;
    localparam int F_OVF = 1;
    localparam int F_HW  = 2;
    localparam int F_TRG = 3;
    localparam int F_SER = 4;
    localparam int F_DSC = 5;

    logic [2:0]  freeze_sel_ff;
    logic        safety_spare_ff;
    logic [1:0]  trig_edge_sel_ff;
    logic [5:0]  flags_ff;
    logic [5:0]  nxt_flags;
    logic [5:0]  masks_ff;
    logic [2:0]  zero_rel_ff;
    logic [2:0]  rst_src_ff;
    logic [2:0]  ld_src_ff;
    logic [2:0]  stick_ff;
    logic [2:0]  host_sel_ff;
    logic        trig_prev_ff;

    function automatic acq_ctrl_pkg::freeze_mode_t freeze_mode(input logic [2:0] code);
        unique case (code)
            3'h1:    freeze_mode = acq_ctrl_pkg::FRZ_COUNTER;
            3'h2:    freeze_mode = acq_ctrl_pkg::FRZ_TRIG_FALL;
            default: freeze_mode = acq_ctrl_pkg::FRZ_HOST;
        endcase
    endfunction

    function automatic acq_ctrl_pkg::line_rst_src_t rst_mode(input logic [2:0] code);
        unique case (code)
            3'h0:    rst_mode = acq_ctrl_pkg::RST_WIN_END;
            3'h1:    rst_mode = acq_ctrl_pkg::RST_FEN_OR_COL;
            3'h2:    rst_mode = acq_ctrl_pkg::RST_COL;
            default: rst_mode = acq_ctrl_pkg::RST_NONE;
        endcase
    endfunction

    function automatic acq_ctrl_pkg::line_ld_src_t ld_mode(input logic [2:0] code);
        unique case (code)
            3'h1:    ld_mode = acq_ctrl_pkg::LD_LINE_EN;
            3'h2:    ld_mode = acq_ctrl_pkg::LD_ENCODER;
            default: ld_mode = acq_ctrl_pkg::LD_NONE;
        endcase
    endfunction

    // Register port decode.
    wire wr_con1 = wr_en && (addr == `ACQ_OFS_CON1);
    wire wr_counter_control_word_two = wr_en && (addr == `ACQ_OFS_COUNTER_CONTROL_WORD_TWO);
    wire wr_mask = wr_en && (addr == `ACQ_OFS_MASK);

    // Trigger edges and the trigger interrupt event.
    wire trig_rise = trigger_in && !trig_prev_ff;
    wire trig_fall = !trigger_in && trig_prev_ff;
    wire acq_ctrl_pkg::edge_sel_t edge_sel = acq_ctrl_pkg::edge_sel_t'(trig_edge_sel_ff);
    wire trig_evt  = ((edge_sel == acq_ctrl_pkg::EDGE_RISE ||
                       edge_sel == acq_ctrl_pkg::EDGE_BOTH) && trig_rise) ||
                     ((edge_sel == acq_ctrl_pkg::EDGE_FALL ||
                       edge_sel == acq_ctrl_pkg::EDGE_BOTH) && trig_fall);

    // Hardware sources of each flag.
    wire [5:0] hw_evt;
    assign hw_evt[F_TAB] = vert_table_irq_column;
    assign hw_evt[F_OVF] = fifo_overflow;
    assign hw_evt[F_HW]  = hw_exception || sync_lost;
    assign hw_evt[F_TRG] = trig_evt;
    assign hw_evt[F_SER] = uart_irq_set;
    assign hw_evt[F_DSC] = descriptor_irq_req;

    // A flag other than the serial flag is selected for host access by its write select code.
    wire [5:0] selected;
    assign selected[F_TAB] = (host_sel_ff == `SEL_TABLE);
    assign selected[F_OVF] = (host_sel_ff == `SEL_OVERFLOW);
    assign selected[F_HW]  = (host_sel_ff == `SEL_FAULT);
    assign selected[F_TRG] = (host_sel_ff == `SEL_TRIGGER);
    assign selected[F_SER] = 1'b0;
    assign selected[F_DSC] = (host_sel_ff == `SEL_DESCRIPTOR);

    // Value the host writes into each flag position of the first word.
    wire [5:0] wr_flag;
    assign wr_flag[F_TAB] = wr_data[24];
    assign wr_flag[F_OVF] = wr_data[25];
    assign wr_flag[F_HW]  = wr_data[26];
    assign wr_flag[F_TRG] = wr_data[27];
    assign wr_flag[F_SER] = 1'b0;
    assign wr_flag[F_DSC] = wr_data[29];

    wire [5:0] host_wr = selected & {6{wr_con1}};

    // Selecting a flag shuts out its source, so a read-modify-write by the
    // host cannot lose or resurrect an event between the read and the write.
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (host_wr[i])
                nxt_flags[i] = wr_flag[i];
            else if (selected[i])
                nxt_flags[i] = flags_ff[i];
            else
                nxt_flags[i] = flags_ff[i] | hw_evt[i];
        end
        // The serial flag only follows the UART; a new event beats the clear.
        nxt_flags[F_SER] = (flags_ff[F_SER] && !uart_host_write) || uart_irq_set;
    end

    wire nxt_irq = |(flags_ff & masks_ff);

    wire freeze_go = host_freeze_cmd ||
        (freeze_mode(freeze_sel_ff) == acq_ctrl_pkg::FRZ_COUNTER && acq_counter_done) ||
        (freeze_mode(freeze_sel_ff) == acq_ctrl_pkg::FRZ_TRIG_FALL && trig_fall);

    wire pos_clear = wr_counter_control_word_two && wr_data[`COUNTER_CONTROL_WORD_TWO_POSCLR_BIT];
    wire ptr_clear = wr_counter_control_word_two && wr_data[`COUNTER_CONTROL_WORD_TWO_PTRCLR_BIT];
    wire line_force_clear = pos_clear || software_reset_strobe || abort_cmd;

    // Read words; bits owned by other blocks read as zero.
    wire [31:0] con1_word = {trig_edge_sel_ff, flags_ff[F_DSC], 1'b0,
                             flags_ff[F_TRG], flags_ff[F_HW], flags_ff[F_OVF],
                             flags_ff[F_TAB], dma_unthrottled_test_ff,
                             safety_spare_ff, freeze_sel_ff, flags_ff[F_SER], 18'h0};
    wire [31:0] counter_control_word_two_word = {1'b1, host_sel_ff, 14'h0, 2'b00,
                             stick_ff, ld_src_ff, rst_src_ff, zero_rel_ff};
    wire [31:0] mask_word = {24'h0, irq_request_ff, 1'b0, masks_ff};
    wire [31:0] stat_word = {{(32 - CNT_W){1'b0}}, line_position_counter};
    wire [31:0] rd_mux    = (addr == `ACQ_OFS_CON1) ? con1_word :
                            (addr == `ACQ_OFS_COUNTER_CONTROL_WORD_TWO) ? counter_control_word_two_word :
                            (addr == `ACQ_OFS_MASK) ? mask_word :
                            (addr == `ACQ_OFS_STAT) ? stat_word : 32'h0;
    wire [31:0] nxt_rd_data = rd_en ? rd_mux : 32'h0;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            freeze_sel_ff           <= 3'h0;
            safety_spare_ff         <= 1'b0;
            dma_unthrottled_test_ff <= 1'b0;
            trig_edge_sel_ff        <= 2'h0;
        end
        else if (wr_con1)
        begin
            freeze_sel_ff           <= wr_data[`CON1_FREEZE_LSB +: 3];
            safety_spare_ff         <= wr_data[`CON1_SAFETY_BIT];
            dma_unthrottled_test_ff <= wr_data[`CON1_DMA_TEST_BIT];
            trig_edge_sel_ff        <= wr_data[`CON1_TRIGCON_LSB +: 2];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_rel_ff <= 3'h0;
            rst_src_ff  <= 3'h0;
            ld_src_ff   <= 3'h0;
            stick_ff    <= 3'h0;
            host_sel_ff <= 3'h0;
        end
        else if (wr_counter_control_word_two)
        begin
            zero_rel_ff <= wr_data[`COUNTER_CONTROL_WORD_TWO_ZERO_LSB +: 3];
            rst_src_ff  <= wr_data[`COUNTER_CONTROL_WORD_TWO_RST_LSB +: 3];
            ld_src_ff   <= wr_data[`COUNTER_CONTROL_WORD_TWO_LD_LSB +: 3];
            stick_ff    <= wr_data[`COUNTER_CONTROL_WORD_TWO_STICK_LSB +: 3];
            host_sel_ff <= wr_data[`COUNTER_CONTROL_WORD_TWO_SEL_LSB +: 3];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            masks_ff <= 6'h00;
        else if (wr_mask)
            masks_ff <= wr_data[5:0];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_ff                <= 6'h00;
            irq_request_ff          <= 1'b0;
            trig_prev_ff            <= 1'b0;
            freeze_request_ff       <= 1'b0;
            frame_counter_clear_ff  <= 1'b0;
            memory_pointer_clear_ff <= 1'b0;
            rd_data_ff              <= `RESET_WORD;
        end
        else
        begin
            flags_ff                <= nxt_flags;
            irq_request_ff          <= nxt_irq;
            trig_prev_ff            <= trigger_in;
            freeze_request_ff       <= freeze_go;
            frame_counter_clear_ff  <= pos_clear;
            memory_pointer_clear_ff <= ptr_clear;
            rd_data_ff              <= nxt_rd_data;
        end
    end

    line_position_counter #(
        .CNT_W                    (CNT_W)
    ) u_line_cnt (
        .mclk                     (mclk),
        .rst_n                    (rst_n),
        .advance                  (line_advance),
        .encoder_in               (encoder_in),
        .frame_enable_in          (frame_enable_in),
        .line_enable_in           (line_enable_in),
        .haw_end                  (haw_end),
        .horiz_table_reset_column (horiz_table_reset_column),
        .horiz_table_load_enable  (horiz_table_load_enable),
        .force_clear              (line_force_clear),
        .zero_release_en          (zero_rel_ff == 3'h1),
        .stick_en                 (stick_ff == 3'h1),
        .rst_src                  (rst_mode(rst_src_ff)),
        .ld_src                   (ld_mode(ld_src_ff)),
        .count_ff                 (line_position_counter)
    );

    a_host_write_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_con1 && host_sel_ff == `SEL_TABLE) |=> flags_ff[F_TAB] == $past(wr_data[24]))
        else $error("selected table flag did not take host value");
    a_unselected_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_con1 && host_sel_ff != `SEL_OVERFLOW && flags_ff[F_OVF]) |=> flags_ff[F_OVF])
        else $error("unselected overflow flag changed by host write");
    a_source_blocked: assert property (@(posedge mclk) disable iff (!rst_n)
        (host_sel_ff == `SEL_FAULT && !wr_con1 && !flags_ff[F_HW]) |=> !flags_ff[F_HW])
        else $error("fault flag set while selected for host");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        (descriptor_irq_req && host_sel_ff != `SEL_DESCRIPTOR)
        |=> flags_ff[F_DSC] ##1 (flags_ff[F_DSC] || $past(wr_con1)))
        else $error("descriptor flag not held");
    a_irq_masked: assert property (@(posedge mclk) disable iff (!rst_n)
        (flags_ff & masks_ff) == 6'h00 |=> !irq_request_ff)
        else $error("request raised with all flags masked");
    a_irq_raised: assert property (@(posedge mclk) disable iff (!rst_n)
        (flags_ff[F_OVF] && masks_ff[F_OVF]) |=> irq_request_ff)
        else $error("masked-in flag raised no request");
    a_serial_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        uart_irq_set |=> flags_ff[F_SER])
        else $error("serial event lost");
    a_trig_rise_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        (trig_edge_sel_ff == 2'h1 && $fell(trigger_in) && !flags_ff[F_TRG]
         && !wr_con1) |=> !flags_ff[F_TRG])
        else $error("falling edge set trigger flag in rising mode");
    a_freeze_trig: assert property (@(posedge mclk) disable iff (!rst_n)
        (freeze_sel_ff == 3'h2 && trig_fall) |=> freeze_request_ff)
        else $error("trigger fall did not request freeze");
    a_freeze_host_only: assert property (@(posedge mclk) disable iff (!rst_n)
        (freeze_sel_ff == 3'h0 && !host_freeze_cmd) |=> !freeze_request_ff)
        else $error("freeze without host command in host mode");
    a_clear_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        pos_clear |=> frame_counter_clear_ff && line_position_counter == '0)
        else $error("position clear strobe missing");
    a_read_latency: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_en && addr == `ACQ_OFS_STAT) |=> rd_data_ff[CNT_W-1:0] == $past(line_position_counter))
        else $error("status read data wrong");
endmodule

// >>> inc/acq_ctrl_regs.svh
/*
  Register map, field positions and reset values of the acquisition interrupt
  and line counter control bank. Assumes a 32-bit word bus with byte addresses.
*/
// What this block does
// - Freeze starts by host command, plus acquisition counter or trigger fall.
// - Unthrottled DMA test bit lets the DMA move data at full rate.
// - Table flag set by table event or host write; host writes need select 1.
// - Overflow flag set by FIFO overflow or host write; host writes need select 2.
// - Fault flag set by fault or sync loss or host write; needs select 3.
// - Trigger flag set by chosen trigger edge or host write; needs select 4.
// - Descriptor flag set by descriptor or host write; host writes need select 5.
// - A flag raises the request only when its mask bit is one.
// - Serial flag is read-only, set by the UART, cleared by a UART write.
// - Edge select: 1 rising, 2 falling, 3 both, 0 none.
// - With zero release on, the line counter halts at zero until encoder rises.
// - Software reset, counter clear strobe and abort always clear the line counter.
// - Line counter clear: 0 window end, 1 frame enable or column, 2 column.
// - Load 2000h on line enable or encoder rise, gated by the load column.
// - With stick on, the line counter holds at 1FF0h until load or reset.
// - Writing one to the counter clear strobe clears both position counters.
// - Writing one to the pointer clear strobe clears the memory pointer.
// - A selected flag cannot be set by its hardware source.
`ifndef ACQ_CTRL_REGS_SVH
`define ACQ_CTRL_REGS_SVH

`define ACQ_OFS_CON1      8'h00
`define ACQ_OFS_COUNTER_CONTROL_WORD_TWO      8'h04
`define ACQ_OFS_MASK      8'h08
`define ACQ_OFS_STAT      8'h0C

`define CON1_FREEZE_LSB   19
`define CON1_SAFETY_BIT   22
`define CON1_DMA_TEST_BIT 23
`define CON1_TRIGCON_LSB  30

`define COUNTER_CONTROL_WORD_TWO_ZERO_LSB     0
`define COUNTER_CONTROL_WORD_TWO_RST_LSB      3
`define COUNTER_CONTROL_WORD_TWO_LD_LSB       6
`define COUNTER_CONTROL_WORD_TWO_STICK_LSB    9
`define COUNTER_CONTROL_WORD_TWO_POSCLR_BIT   12
`define COUNTER_CONTROL_WORD_TWO_PTRCLR_BIT   13
`define COUNTER_CONTROL_WORD_TWO_SEL_LSB      28

`define SEL_TABLE         3'h1
`define SEL_OVERFLOW      3'h2
`define SEL_FAULT         3'h3
`define SEL_TRIGGER       3'h4
`define SEL_DESCRIPTOR    3'h5

`define LINE_LOAD_VALUE   14'h2000
`define LINE_STICK_VALUE  14'h1FF0
`define RESET_WORD        32'h0000_0000

`endif

// >>> inc/acq_ctrl_pkg.sv
/*
  Mode types of the acquisition control bank. Needs nothing else.
*/
package acq_ctrl_pkg;
    typedef enum logic [1:0] {FRZ_HOST, FRZ_COUNTER, FRZ_TRIG_FALL} freeze_mode_t;
    typedef enum logic [1:0] {RST_NONE, RST_WIN_END, RST_FEN_OR_COL, RST_COL} line_rst_src_t;
    typedef enum logic [1:0] {LD_NONE, LD_LINE_EN, LD_ENCODER} line_ld_src_t;
    typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;
endpackage

// >>> verilog/line_position_counter.sv
/*
  Horizontal control table position counter with clear, load, stick and
  zero release. Camera inputs are synchronous to mclk.
*/
`timescale 1ns/10ps
`include "acq_ctrl_regs.svh"
module line_position_counter #(
    parameter int CNT_W = 14
) (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic                         advance,
    input  wire logic                         encoder_in,
    input  wire logic                         frame_enable_in,
    input  wire logic                         line_enable_in,
    input  wire logic                         haw_end,
    input  wire logic                         horiz_table_reset_column,
    input  wire logic                         horiz_table_load_enable,
    input  wire logic                         force_clear,
    input  wire logic                         zero_release_en,
    input  wire logic                         stick_en,
    input  wire acq_ctrl_pkg::line_rst_src_t  rst_src,
    input  wire acq_ctrl_pkg::line_ld_src_t   ld_src,
    output logic [CNT_W-1:0]                  count_ff
);
    logic             enc_prev_ff;
    logic             fen_prev_ff;
    logic             len_prev_ff;
    logic             released_ff;
    wire              enc_rise = encoder_in & ~enc_prev_ff;
    wire              fen_rise = frame_enable_in & ~fen_prev_ff;
    wire              len_rise = line_enable_in & ~len_prev_ff;
    wire              src_reset;
    wire              do_load;
    wire              hold;
    wire              at_zero  = (count_ff == '0);
    wire              at_stick = (count_ff == `LINE_STICK_VALUE);
    wire  [CNT_W-1:0] nxt_count;
    wire              nxt_released;

    assign src_reset = (rst_src == acq_ctrl_pkg::RST_WIN_END    && haw_end) ||
                       (rst_src == acq_ctrl_pkg::RST_FEN_OR_COL &&
                        (fen_rise || horiz_table_reset_column)) ||
                       (rst_src == acq_ctrl_pkg::RST_COL && horiz_table_reset_column);
    assign do_load   = horiz_table_load_enable &&
                       ((ld_src == acq_ctrl_pkg::LD_LINE_EN && len_rise) ||
                        (ld_src == acq_ctrl_pkg::LD_ENCODER && enc_rise));
    // Holding at zero gives way in the very cycle that the encoder rises.
    assign hold      = (stick_en && at_stick) ||
                       (zero_release_en && at_zero && !released_ff && !enc_rise);
    assign nxt_count = (force_clear || src_reset) ? '0 :
                       do_load ? `LINE_LOAD_VALUE :
                       (advance && !hold) ? count_ff + 1'b1 : count_ff;
    assign nxt_released = enc_rise || (released_ff && !force_clear && !src_reset);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_ff    <= '0;
            enc_prev_ff <= 1'b0;
            fen_prev_ff <= 1'b0;
            len_prev_ff <= 1'b0;
            released_ff <= 1'b0;
        end
        else
        begin
            count_ff    <= nxt_count;
            enc_prev_ff <= encoder_in;
            fen_prev_ff <= frame_enable_in;
            len_prev_ff <= line_enable_in;
            released_ff <= nxt_released;
        end
    end

    a_clear_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        force_clear |=> count_ff == '0)
        else $error("line counter not cleared");
    a_load_value: assert property (@(posedge mclk) disable iff (!rst_n)
        (do_load && !force_clear && !src_reset) |=> count_ff == `LINE_LOAD_VALUE)
        else $error("line counter load value wrong");
    a_stick_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (stick_en && at_stick && !force_clear && !src_reset && !do_load)
        |=> count_ff == `LINE_STICK_VALUE)
        else $error("line counter left stick value");
    a_zero_halt: assert property (@(posedge mclk) disable iff (!rst_n)
        (zero_release_en && at_zero && !released_ff && !enc_rise && !do_load)
        |=> count_ff == '0)
        else $error("line counter left zero without encoder");
endmodule

// >>> verification/camera_side_model.sv
/*
  Camera side model: trigger, encoder, line enable, line advance and the
  horizontal table load column. Assumes the bench steers it from mclk.
*/
`timescale 1ns/10ps
module camera_side_model (
    input  wire logic mclk,
    output logic      trigger_in,
    output logic      encoder_in,
    output logic      line_enable_in,
    output logic      line_advance,
    output logic      horiz_table_load_enable
);
    // Levels move only just after a rising edge, so sampling is never racy.
    task automatic drive(input logic [4:0] v);
        @(posedge mclk);
        {trigger_in, encoder_in, line_enable_in, line_advance, horiz_table_load_enable} <= v;
    endtask
    initial
    begin
        {trigger_in, encoder_in, line_enable_in, line_advance, horiz_table_load_enable} = 5'h00;
    end
endmodule

// >>> verification/tb_acq_irq_and_line_counter_ctrl.sv
/*
  Self-checking bench of the acquisition control bank. Speaks the one-cycle
  register port; camera levels come from the camera side model, except window end, pulsed by the bench, and frame enable and the reset column, held low.
*/
`timescale 1ns/10ps
module tb_acq_irq_and_line_counter_ctrl;
    logic        mclk, rst_n, wr_en, rd_en, trigger_in, encoder_in, frame_enable_in;
    logic        line_enable_in, line_advance, haw_end, horiz_table_reset_column;
    logic        horiz_table_load_enable, vert_table_irq_column, fifo_overflow;
    logic        hw_exception, sync_lost, descriptor_irq_req, uart_irq_set;
    logic        uart_host_write, software_reset_strobe, abort_cmd, host_freeze_cmd;
    logic        acq_counter_done, freeze_request_ff, dma_unthrottled_test_ff;
    logic        irq_request_ff, frame_counter_clear_ff, memory_pointer_clear_ff;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data_ff;
    logic [13:0] line_position_counter;
    int          errors, checked;
    int          fbit [5] = '{24, 25, 26, 27, 29};
    // Event strobes, bit 11 down to 0: overflow, abort, table column, exception,
    // sync loss, descriptor, serial set, serial clear, soft reset, host freeze,
    // counter done, window end.
    logic [11:0] ev;

    assign {fifo_overflow, abort_cmd, vert_table_irq_column, hw_exception, sync_lost,
            descriptor_irq_req, uart_irq_set, uart_host_write, software_reset_strobe,
            host_freeze_cmd, acq_counter_done, haw_end} = ev;

    acq_irq_and_line_counter_ctrl DUT (.*);
    camera_side_model cam (.*);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge mclk);
        wr_en   <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(n, e, rd_data_ff);
    endtask
    task pulse(input int k, input int w);
        @(posedge mclk);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
        repeat (w) @(posedge mclk);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // A hung run is cut short here and counted as a mismatch.
    initial
    begin
        #200000;
        errors++;
        give_verdict();
    end

    initial
    begin
        {rst_n, wr_en, rd_en, addr, wr_data, ev} = '0;
        {frame_enable_in, horiz_table_reset_column} = '0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h04, 32'h8000_0000, "counter_control_word_two reset");
        rd(8'h10, 32'h0000_0000, "unmapped");
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h04, {1'b0, 3'(i + 1), 28'h0});
            wr(8'h00, 32'h2F00_0000);
            rd(8'h00, 32'h1 << fbit[i], "host flag set");
            wr(8'h00, 32'h0000_0000);
            rd(8'h00, 32'h0000_0000, "host flag clear");
        end
        $display("test host flags done");
        wr(8'h04, 32'h0000_0000);
        pulse(11, 3);
        chk("irq masked", 32'h0, {31'h0, irq_request_ff});
        rd(8'h00, 32'h0200_0000, "overflow event");
        wr(8'h08, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, irq_request_ff});
        wr(8'h04, 32'h2000_0000);
        wr(8'h00, 32'h0000_0000);
        pulse(11, 3);
        rd(8'h00, 32'h0000_0000, "source blocked");
        $display("test mask and select done");
        wr(8'h04, 32'h0000_0000);
        cam.drive(5'h10);
        wr(8'h00, 32'h4000_0000);
        cam.drive(5'h00);
        rd(8'h00, 32'h4000_0000, "fall ignored");
        wr(8'h00, 32'h8000_0000);
        cam.drive(5'h10);
        rd(8'h00, 32'h8000_0000, "rise ignored");
        cam.drive(5'h00);
        rd(8'h00, 32'h8800_0000, "fall sets flag");
        wr(8'h00, 32'h0080_0000);
        chk("dma test", 32'h1, {31'h0, dma_unthrottled_test_ff});
        $display("test trigger and dma done");
        cam.drive(5'h02);
        repeat (4) @(posedge mclk);
        cam.drive(5'h00);
        rd(8'h0C, 32'h0000_0005, "line count");
        wr(8'h04, 32'h0000_1000);
        chk("frame clear", 32'h1, {31'h0, frame_counter_clear_ff});
        rd(8'h0C, 32'h0000_0000, "line cleared");
        wr(8'h04, 32'h0000_2000);
        chk("pointer clear", 32'h1, {31'h0, memory_pointer_clear_ff});
        wr(8'h04, 32'h0000_0040);
        cam.drive(5'h01);
        cam.drive(5'h05);
        cam.drive(5'h01);
        rd(8'h0C, 32'h0000_2000, "line load");
        pulse(10, 3);
        rd(8'h0C, 32'h0000_0000, "abort clear");
        cam.drive(5'h02);
        cam.drive(5'h00);
        rd(8'h0C, 32'h0000_0001, "line advance");
        pulse(0, 0);
        rd(8'h0C, 32'h0000_0000, "window end clear");
        cam.drive(5'h02);
        cam.drive(5'h00);
        pulse(3, 0);
        rd(8'h0C, 32'h0000_0000, "soft reset clear");
        wr(8'h04, 32'h0000_0001);
        cam.drive(5'h02);
        cam.drive(5'h00);
        rd(8'h0C, 32'h0000_0000, "zero halt");
        cam.drive(5'h0A);
        cam.drive(5'h00);
        rd(8'h0C, 32'h0000_0001, "zero release");
        $display("test line counter done");
        pulse(9, 0);
        pulse(7, 0);
        pulse(6, 0);
        pulse(5, 0);
        rd(8'h00, 32'h2D84_0000, "source flags");
        pulse(4, 0);
        wr(8'h04, 32'h3000_0000);
        wr(8'h00, 32'h0080_0000);
        pulse(8, 0);
        rd(8'h00, 32'h2980_0000, "fault blocked");
        wr(8'h04, 32'h0000_0000);
        pulse(8, 0);
        rd(8'h00, 32'h2D80_0000, "fault event");
        wr(8'h08, 32'h0000_0021);
        rd(8'h08, 32'h0000_00A1, "mask and request");
        wr(8'h00, 32'h0008_0000);
        pulse(1, 0);
        chk("freeze counter", 32'h1, {31'h0, freeze_request_ff});
        wr(8'h00, 32'h0000_0000);
        pulse(1, 0);
        chk("freeze host only", 32'h0, {31'h0, freeze_request_ff});
        pulse(2, 0);
        chk("freeze host cmd", 32'h1, {31'h0, freeze_request_ff});
        $display("test sources and freeze done");
        give_verdict();
    end
endmodule
